// >>> hw/sio_pkg.sv
// Purpose: constants and types shared by the safe i/o monitor
// Assumes: 50 MHz clock, classic wishbone with 32-bit data
// Notes:   every offset is a byte address, one aligned word each
package sio_pkg;

  // clock and discrepancy timing
  localparam int CLK_HZ          = 50_000_000;
  localparam int DISC_TIME_MS    = 100;
  localparam int DISC_CYCLES_DEF = DISC_TIME_MS * (CLK_HZ / 1000);
  localparam int CNT_W           = 23;

  // register byte offsets
  localparam logic [7:0] OFS_SEL0    = 8'h00; // trigger select, output 1
  localparam logic [7:0] OFS_SEL1    = 8'h04;
  localparam logic [7:0] OFS_SEL2    = 8'h08;
  localparam logic [7:0] OFS_SEL3    = 8'h0C;
  localparam logic [7:0] OFS_CTRL    = 8'h10;
  localparam logic [7:0] OFS_IN_STS  = 8'h14;
  localparam logic [7:0] OFS_OUT_STS = 8'h18;
  localparam logic [7:0] OFS_FLT_STS = 8'h1C;

  // control word fields
  localparam int CTRL_DIN_EN  = 0; // dual input mode
  localparam int CTRL_DOUT_EN = 1; // dual output mode
  localparam int CTRL_FLT_CLR = 2; // write one to clear the fault

  // status word fields
  localparam int STS_DUAL_LVL = 4;
  localparam int STS_DUAL_BAD = 5;
  localparam int FLT_FAULT    = 0;
  localparam int FLT_SAFE     = 1;

  // trigger selector codes and reset values
  localparam logic [7:0] SEL_OFF    = 8'h00;
  localparam logic [7:0] SEL_ALWAYS = 8'hFF;
  localparam logic [3:0][7:0] SEL_RST = {8'hFF, 8'h00, 8'hFF, 8'hFF};
  localparam logic       DIN_EN_RST  = 1'b1;
  localparam logic       DOUT_EN_RST = 1'b0;

  // discrepancy monitor states
  typedef enum logic [2:0] {
    MON_AGREE  = 3'b001,
    MON_DIFFER = 3'b010,
    MON_FAULT  = 3'b100
  } sio_mon_t;

  // whole state of the monitor
  typedef struct packed {
    logic             ack;
    logic [31:0]      dat;
    logic [3:0][7:0]  sel;
    logic             din_en;
    logic             dout_en;
    logic [3:0]       sync1;
    logic [3:0]       sync2;
    logic [3:0]       in_lvl;
    logic             din_lvl;
    logic             din_bad;
    logic [CNT_W-1:0] cnt;
    sio_mon_t         mon;
    logic             fault;
    logic [3:0]       outs;
  } sio_state_t;

endpackage

// >>> hw/sio_monitor.sv
// Purpose: safe input pairing, discrepancy watch and safe output drive
// Assumes: trigger sources arrive on clk_i, safe inputs are raw pins
// Notes:   registers on classic wishbone, ack one cycle after strobe
//
// What this block does
// R1: dual input of inputs 1 and 2 reads 0 when both low, 1 when both high.
// R2: a disagreeing pair reads as an i/o failure instead of a level.
// R3: in dual mode a mismatch held over 100 ms raises an i/o failure fault.
// R4: raising that fault puts the drive into its safe state.
// R5: four single safe inputs are each readable as 0 or 1.
// R6: in dual output mode outputs one and two are driven as one output.
// R7: the dual output reads 0 when both low, 1 when both high, else undefined.
// R8: four single safe outputs are each readable as the driven level.
// R9: each trigger selector is 8-bit read/write, resetting to on, on, off, on.
// R10: in single mode each output follows its source, 0x00 off, 0xFF on.
// R11: the mismatch timer restarts from zero whenever the pair agrees again.
`timescale 1ns/1ps
`default_nettype none

module sio_monitor
  import sio_pkg::*;
#(
  parameter int DISC_CYCLES = DISC_CYCLES_DEF
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic [3:0]   safe_input_i,
  input  wire logic [255:0] trigger_src_i,
  output logic      [3:0]   safe_output_o,
  output logic              io_fault_o,
  output logic              safe_state_o
);

  sio_state_t r_reg;
  sio_state_t r_next;

  logic wr_hit;
  logic rd_hit;
  logic pair_differ;

  // selector decode: off, always on, or the chosen safety function
  function automatic logic sel_drive(input logic [7:0]   code,
                                     input logic [255:0] src);
    if (code == SEL_OFF) begin
      return 1'b0;
    end else if (code == SEL_ALWAYS) begin
      return 1'b1;
    end
    return src[code];
  endfunction

  // bus access qualifiers; ack drops the cycle after it was given
  assign wr_hit      = wb_cyc_i && wb_stb_i && !r_reg.ack && wb_we_i;
  assign rd_hit      = wb_cyc_i && wb_stb_i && !r_reg.ack && !wb_we_i;
  assign pair_differ = r_reg.sync2[0] != r_reg.sync2[1];

  // next state of the whole block
  always_comb begin
    r_next     = r_reg;
    r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;

    // two flops on the raw pins before any logic looks at them
    r_next.sync1 = safe_input_i;
    r_next.sync2 = r_reg.sync1;

    // R5: single input levels
    r_next.in_lvl = r_reg.sync2;
    // R1: dual level only meaningful when the pair agrees
    r_next.din_lvl = r_reg.sync2[0] && !pair_differ;
    // R2: disagreement reported as failure, not as a level
    r_next.din_bad = pair_differ;

    // register writes, low byte lane carries every field
    if (wr_hit && wb_sel_i[0]) begin
      case (wb_adr_i)
        // R9: selectors are plain read/write bytes
        OFS_SEL0: r_next.sel[0] = wb_dat_i[7:0];
        OFS_SEL1: r_next.sel[1] = wb_dat_i[7:0];
        OFS_SEL2: r_next.sel[2] = wb_dat_i[7:0];
        OFS_SEL3: r_next.sel[3] = wb_dat_i[7:0];
        OFS_CTRL: begin
          r_next.din_en  = wb_dat_i[CTRL_DIN_EN];
          r_next.dout_en = wb_dat_i[CTRL_DOUT_EN];
        end
        default: ;
      endcase
    end

    // discrepancy monitor
    case (r_reg.mon)
      MON_AGREE: begin
        r_next.cnt = '0;
        if (r_reg.din_en && pair_differ) begin
          r_next.mon = MON_DIFFER;
        end
      end
      MON_DIFFER: begin
        if (!r_reg.din_en || !pair_differ) begin
          // R11: agreement restarts the timer
          r_next.cnt = '0;
          r_next.mon = MON_AGREE;
        end else if (r_reg.cnt >= CNT_W'(DISC_CYCLES)) begin
          // R3: mismatch outlasted the limit
          r_next.mon   = MON_FAULT;
          r_next.fault = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt + CNT_W'(1);
        end
      end
      MON_FAULT: begin
        r_next.cnt = '0;
        // clear only once the pair agrees, so a live fault wins
        if (wr_hit && wb_sel_i[0] && wb_adr_i == OFS_CTRL &&
            wb_dat_i[CTRL_FLT_CLR] && !pair_differ) begin
          r_next.fault = 1'b0;
          r_next.mon   = MON_AGREE;
        end
      end
      default: begin
        r_next.mon   = MON_FAULT;
        r_next.fault = 1'b1;
      end
    endcase

    // R10: each output follows its own selector
    for (int i = 0; i < 4; i++) begin
      r_next.outs[i] = sel_drive(r_reg.sel[i], trigger_src_i);
    end
    // R6: paired outputs share the first selector
    if (r_reg.dout_en) begin
      r_next.outs[1] = r_next.outs[0];
    end
    // R4: safe state de-energises every output
    if (r_reg.fault) begin
      r_next.outs = '0;
    end

    // read mux, unmapped words read zero
    r_next.dat = '0;
    if (rd_hit) begin
      case (wb_adr_i)
        OFS_SEL0:    r_next.dat[7:0] = r_reg.sel[0];
        OFS_SEL1:    r_next.dat[7:0] = r_reg.sel[1];
        OFS_SEL2:    r_next.dat[7:0] = r_reg.sel[2];
        OFS_SEL3:    r_next.dat[7:0] = r_reg.sel[3];
        OFS_CTRL: begin
          r_next.dat[CTRL_DIN_EN]  = r_reg.din_en;
          r_next.dat[CTRL_DOUT_EN] = r_reg.dout_en;
        end
        OFS_IN_STS: begin
          r_next.dat[3:0]          = r_reg.in_lvl;
          r_next.dat[STS_DUAL_LVL] = r_reg.din_lvl;
          r_next.dat[STS_DUAL_BAD] = r_reg.din_bad;
        end
        OFS_OUT_STS: begin
          // R8: levels as driven on the pins
          r_next.dat[3:0]          = r_reg.outs;
          // R7: dual level high only when both high
          r_next.dat[STS_DUAL_LVL] = r_reg.outs[0] && r_reg.outs[1];
          r_next.dat[STS_DUAL_BAD] = r_reg.outs[0] != r_reg.outs[1];
        end
        OFS_FLT_STS: begin
          r_next.dat[FLT_FAULT] = r_reg.fault;
          r_next.dat[FLT_SAFE]  = r_reg.fault;
        end
        default: ;
      endcase
    end
  end

  // single register stage; reset values are constants only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg         <= '0;
      r_reg.sel     <= SEL_RST; // R9: selector reset values
      r_reg.din_en  <= DIN_EN_RST;
      r_reg.dout_en <= DOUT_EN_RST;
      r_reg.mon     <= MON_AGREE;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign wb_ack_o      = r_reg.ack;
  assign wb_dat_o      = r_reg.dat;
  assign safe_output_o = r_reg.outs;
  assign io_fault_o    = r_reg.fault;
  assign safe_state_o  = r_reg.fault;

  // checks on the design's own behaviour
  dual_level_a: assert property ( // R1
    @(posedge clk_i) disable iff (rst_i)
    $past(r_reg.sync2[1:0]) == 2'b11 |-> r_reg.din_lvl)
    else $error("dual input not high with both inputs high");

  dual_fail_a: assert property ( // R2
    @(posedge clk_i) disable iff (rst_i)
    (r_reg.sync2[0] != r_reg.sync2[1]) |=> r_reg.din_bad && !r_reg.din_lvl)
    else $error("pair mismatch not reported as failure");

  disc_timeout_a: assert property ( // R3
    @(posedge clk_i) disable iff (rst_i)
    r_reg.mon == MON_DIFFER && r_reg.din_en && pair_differ &&
    r_reg.cnt >= CNT_W'(DISC_CYCLES) |=> r_reg.fault)
    else $error("discrepancy fault missing after timeout");

  no_early_a: assert property ( // R3
    @(posedge clk_i) disable iff (rst_i)
    $rose(r_reg.fault) |-> $past(r_reg.cnt) >= CNT_W'(DISC_CYCLES))
    else $error("discrepancy fault raised too early");

  safe_state_a: assert property ( // R4
    @(posedge clk_i) disable iff (rst_i)
    r_reg.fault |-> safe_state_o ##1 safe_output_o == 4'h0)
    else $error("fault did not force safe state");

  single_in_a: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    ##1 r_reg.in_lvl == $past(r_reg.sync2))
    else $error("single input level stale");

  dual_out_a: assert property ( // R6
    @(posedge clk_i) disable iff (rst_i)
    r_reg.dout_en ##1 r_reg.dout_en |-> safe_output_o[1] == safe_output_o[0])
    else $error("paired outputs differ");

  out_read_a: assert property ( // R8
    @(posedge clk_i) disable iff (rst_i)
    rd_hit && wb_adr_i == OFS_OUT_STS |=> wb_ack_o &&
    wb_dat_o[3:0] == $past(r_reg.outs) &&
    wb_dat_o[STS_DUAL_LVL] == &$past(r_reg.outs[1:0]))
    else $error("output status read wrong");

  sel_reset_a: assert property ( // R9
    @(posedge clk_i)
    $past(rst_i) |-> r_reg.sel == SEL_RST)
    else $error("selector reset value wrong");

  sel_off_a: assert property ( // R10
    @(posedge clk_i) disable iff (rst_i)
    r_reg.sel[2] == SEL_OFF |=> !safe_output_o[2])
    else $error("output driven with selector off");

  sel_on_a: assert property ( // R10
    @(posedge clk_i) disable iff (rst_i)
    r_reg.sel[3] == SEL_ALWAYS && !r_reg.fault |=> safe_output_o[3])
    else $error("always-on output not driven");

  timer_restart_a: assert property ( // R11
    @(posedge clk_i) disable iff (rst_i)
    r_reg.mon == MON_DIFFER && !pair_differ |=> r_reg.cnt == '0)
    else $error("discrepancy timer not restarted");

  ack_pulse_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // discrepancy side: set wins, bounded count, idle in single mode
  fault_hold_a: assert property ( // R3
    @(posedge clk_i) disable iff (rst_i)
    r_reg.fault && pair_differ |=> r_reg.fault)
    else $error("fault cleared while the pair still differs");

  cnt_bound_a: assert property ( // R3
    @(posedge clk_i) disable iff (rst_i)
    r_reg.cnt <= CNT_W'(DISC_CYCLES))
    else $error("discrepancy count ran past its limit");

  disc_idle_a: assert property ( // R3
    @(posedge clk_i) disable iff (rst_i)
    !r_reg.din_en && r_reg.mon != MON_FAULT |=> r_reg.mon == MON_AGREE)
    else $error("discrepancy timer ran in single input mode");

  dual_low_a: assert property ( // R1
    @(posedge clk_i) disable iff (rst_i)
    $past(r_reg.sync2[1:0]) == 2'b00 |-> !r_reg.din_lvl && !r_reg.din_bad)
    else $error("dual input not low with both inputs low");

  in_read_a: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    rd_hit && wb_adr_i == OFS_IN_STS |=> wb_ack_o &&
    wb_dat_o[3:0] == $past(r_reg.in_lvl) &&
    wb_dat_o[STS_DUAL_BAD] == $past(r_reg.din_bad))
    else $error("input status read wrong");

  out_pair_a: assert property ( // R7
    @(posedge clk_i) disable iff (rst_i)
    rd_hit && wb_adr_i == OFS_OUT_STS |=>
    wb_dat_o[STS_DUAL_BAD] == ^$past(r_reg.outs[1:0]))
    else $error("output pair mismatch bit wrong");

  sel_write_a: assert property ( // R9
    @(posedge clk_i) disable iff (rst_i)
    wr_hit && wb_sel_i[0] && wb_adr_i == OFS_SEL2 |=>
    r_reg.sel[2] == $past(wb_dat_i[7:0]))
    else $error("selector write not stored");

  src_follow_a: assert property ( // R10
    @(posedge clk_i) disable iff (rst_i)
    r_reg.sel[2] != SEL_OFF && r_reg.sel[2] != SEL_ALWAYS &&
    !r_reg.fault |=>
    safe_output_o[2] == $past(trigger_src_i[r_reg.sel[2]]))
    else $error("output not following its selected source");

  // bus timing the master leans on; data is zero between answers
  bus_answer_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");

  dat_idle_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside an answer");

  fault_seen_c: cover property (
    @(posedge clk_i) disable iff (rst_i) $rose(r_reg.fault));

  mismatch_heal_c: cover property (
    @(posedge clk_i) disable iff (rst_i)
    r_reg.mon == MON_DIFFER ##1 r_reg.mon == MON_AGREE);

  fault_clear_c: cover property (
    @(posedge clk_i) disable iff (rst_i) $fell(r_reg.fault));

  dual_out_c: cover property (
    @(posedge clk_i) disable iff (rst_i)
    r_reg.dout_en && safe_output_o[1:0] == 2'b11);

  timer_full_c: cover property (
    @(posedge clk_i) disable iff (rst_i)
    r_reg.mon == MON_DIFFER && r_reg.cnt == CNT_W'(DISC_CYCLES));

endmodule // sio_monitor

`default_nettype wire

// >>> testbench/sio_field.sv
// Purpose: field model of the safety sensors and actuator relays
// Assumes: contacts settle before the rising edge, no bounce
// Notes:   one flop of lag each way, like an input filter or a relay
`timescale 1ns/1ps
`default_nettype none

module sio_field (
  input  wire logic       clk_i,
  input  wire logic [3:0] lvl_i,
  input  wire logic [3:0] outs_i,
  output logic      [3:0] pins_o = 4'h0,
  output logic      [3:0] act_o = 4'h0
);
  // sensor contacts and relay coils sampled once a clock
  always_ff @(posedge clk_i) begin
    pins_o <= lvl_i;
    act_o  <= outs_i; // coil pulls in a cycle late
  end
endmodule // sio_field

`default_nettype wire

// >>> testbench/sio_monitor_tb_top.sv
// Purpose: self-checking bench for the safe i/o monitor
// Assumes: short discrepancy count so the run stays small
// Notes:   each scenario task drives and judges on its own
`timescale 1ns/1ps
`default_nettype none

module sio_monitor_tb_top;
  import sio_pkg::*;
  localparam int DISC = 20;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  wdat = 32'h0;
  logic [31:0]  rdo;
  logic         ack;
  logic [3:0]   lvl = 4'h0;
  logic [3:0]   pins;
  logic [3:0]   outs;
  logic [3:0]   act;
  logic [255:0] trig = '0;
  logic         flt;
  logic         safe;
  int           err_total = 0;
  int           cmp_count = 0;

  // 50 MHz
  always #10 clk_i = ~clk_i;

  sio_monitor #(.DISC_CYCLES(DISC)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdo), .wb_ack_o(ack), .safe_input_i(pins),
    .trigger_src_i(trig), .safe_output_o(outs), .io_fault_o(flt),
    .safe_state_o(safe));

  sio_field u_field (
    .clk_i(clk_i), .lvl_i(lvl), .outs_i(outs), .pins_o(pins),
    .act_o(act));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk("ack", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] m, exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q & m, exp);
  endtask

  task automatic t_reset();
    rd("sel1", OFS_SEL0, 32'hFF, 32'hFF);
    rd("sel2", OFS_SEL1, 32'hFF, 32'hFF);
    rd("sel3", OFS_SEL2, 32'hFF, 32'h00);
    rd("sel4", OFS_SEL3, 32'hFF, 32'hFF);
    chk("outs", 32'(outs), 32'hB);
    rd("osts", OFS_OUT_STS, 32'h3F, 32'h1B);
    rd("void", 8'h20, 32'hFFFF_FFFF, 32'h0);
  endtask

  task automatic t_select();
    wr(OFS_SEL2, 32'h05);
    rd("sel3", OFS_SEL2, 32'hFF, 32'h05);
    trig[5] <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("o3on", 32'(outs[2]), 32'h1);
    trig[5] <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("o3off", 32'(outs[2]), 32'h0);
    wr(OFS_SEL3, 32'h00);
    repeat (2) @(posedge clk_i);
    chk("o4off", 32'(outs[3]), 32'h0);
    rd("osts", OFS_OUT_STS, 32'hF, 32'h3);
    wr(OFS_SEL3, 32'hFF);
  endtask

  task automatic t_inputs();
    logic [5:0]  e;
    logic [31:0] m;
    for (int i = 0; i < 16; i += 5) begin
      lvl <= 4'(i);
      repeat (5) @(posedge clk_i);
      e = {i[0] ^ i[1], i[0] & i[1], 4'(i)};
      m = e[5] ? 32'h2F : 32'h3F; // dual level undefined on mismatch
      rd("ists", OFS_IN_STS, m, 32'(e) & m);
    end
    lvl <= 4'h0;
  endtask

  task automatic t_dual_out();
    wr(OFS_CTRL, 32'h3);
    wr(OFS_SEL1, 32'h00); // must be ignored while paired
    repeat (3) @(posedge clk_i);
    chk("pair", 32'(outs[1:0]), 32'h3);
    chk("coil", 32'(act[1:0]), 32'h3);
    rd("dual", OFS_OUT_STS, 32'h30, 32'h10);
    wr(OFS_SEL0, 32'h00);
    repeat (3) @(posedge clk_i);
    chk("pair0", 32'(outs[1:0]), 32'h0);
    rd("dual0", OFS_OUT_STS, 32'h30, 32'h00);
    wr(OFS_SEL0, 32'hFF);
    wr(OFS_CTRL, 32'h1);
  endtask

  task automatic t_disc();
    lvl <= 4'h1;
    repeat (DISC - 4) @(posedge clk_i);
    chk("early", 32'(flt), 32'h0);
    lvl <= 4'h3;
    repeat (4) @(posedge clk_i);
    lvl <= 4'h1;
    repeat (DISC - 4) @(posedge clk_i);
    chk("restart", 32'(flt), 32'h0);
    repeat (DISC - 4) @(posedge clk_i);
    chk("fault", 32'(flt), 32'h1);
    chk("safe", 32'(safe), 32'h1);
    chk("quiet", 32'(outs), 32'h0);
    rd("fsts", OFS_FLT_STS, 32'h3, 32'h3);
    rd("dbad", OFS_IN_STS, 32'h20, 32'h20);
    lvl <= 4'h0;
    repeat (5) @(posedge clk_i);
    wr(OFS_CTRL, 32'h5);
    repeat (2) @(posedge clk_i);
    chk("clear", 32'(flt), 32'h0);
    wr(OFS_CTRL, 32'h0);
    lvl <= 4'h2;
    repeat (3 * DISC) @(posedge clk_i);
    chk("single", 32'(flt), 32'h0);
    lvl <= 4'h0;
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_select();
    t_inputs();
    t_dual_out();
    t_disc();
    summarize();
  end

  // hang guard, well beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    summarize();
  end
endmodule // sio_monitor_tb_top

`default_nettype wire
